/* slsm_regs.vh */
// Functional notes
// - format 13 carries 9-bit samples, 8B/10B, 8 or 4 lanes, dual/single only.
// - format 13 container is sample then one zero; lane k carries k, k+4, k+8, k+12.
// - format 13 dual parts put channel B on lanes four to seven, same interleave.
// - format 14 carries 9-bit samples, 64B/66B, on 8, 4 or 2 lanes.
// - format 14 container is sample then three zeros; lane pair splits even/odd.
// - format 14 channel B on lanes two/three for dual or quad parts only.
// - format 14 quad parts put channel C on lanes four/five, D on six/seven.
// - format 15 carries 9-bit samples, 64B/66B, 8 or 4 lanes, dual/single only.
`ifndef SLSM_REGS_VH
`define SLSM_REGS_VH

// link format codes
`define SLSM_FMT_W          4
`define SLSM_FMT_13         4'hd
`define SLSM_FMT_14         4'he
`define SLSM_FMT_15         4'hf

// channel variant codes
`define SLSM_VAR_W          2
`define SLSM_VAR_SINGLE     2'h0
`define SLSM_VAR_DUAL       2'h1
`define SLSM_VAR_QUAD       2'h2

// sample frame geometry
`define SLSM_SMP_W          9
`define SLSM_CHANNELS       4
`define SLSM_SMP_PER_CH     16
`define SLSM_FRAME_W        576
`define SLSM_LANES          8
`define SLSM_LANE_W         40

// container layout
`define SLSM_CONT10_W       10
`define SLSM_CONT12_W       12
`define SLSM_PAD10          1'h0
`define SLSM_PAD12          3'h0

// buffering
`define SLSM_FIFO_DEPTH     4
`define SLSM_FIFO_AW        2

`endif

/* slsm_fifo.v */
`timescale 1ns/10ps
module slsm_fifo #(
    parameter WIDTH = 576,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             clock,
    input  wire             rst,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];

    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // slsm_fifo

/* slsm_mapper.v */
`timescale 1ns/10ps
`include "slsm_regs.vh"
module slsm_mapper (
    // clock and reset
    input  wire                         clock,
    input  wire                         rst,
    // configuration
    input  wire [`SLSM_FMT_W-1:0]       link_format_select,
    input  wire [`SLSM_VAR_W-1:0]       channel_variant,
    // sample frames from converter cores
    input  wire                         smp_valid,
    output wire                         smp_ready,
    input  wire [`SLSM_FRAME_W-1:0]     smp_frame,
    // lane frames to link layer
    output reg                          lane_valid,
    input  wire                         lane_ready,
    output reg  [`SLSM_LANES*`SLSM_LANE_W-1:0] lane_data,
    output reg  [`SLSM_LANES-1:0]       lane_enable,
    // status
    output reg                          config_error,
    output reg                          frame_dropped
);
    wire                     f_valid;
    wire                     f_ready;
    wire [`SLSM_FRAME_W-1:0] f_data;
    wire [`SLSM_LANES*`SLSM_LANE_W-1:0] mapped;
    wire [`SLSM_LANES-1:0]   next_enable;
    wire [`SLSM_LANES-1:0]   lane_on;
    reg                      cfg_ok;
    reg  [`SLSM_LANES*`SLSM_LANE_W-1:0] next_data;

    slsm_fifo #(
        .WIDTH (`SLSM_FRAME_W),
        .DEPTH (`SLSM_FIFO_DEPTH),
        .AW    (`SLSM_FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (smp_valid),
        .in_ready  (smp_ready),
        .in_data   (smp_frame),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // channels present for a variant
    function [2:0] chan_count;
        input [`SLSM_VAR_W-1:0] v;
        begin
            case (v)
                `SLSM_VAR_SINGLE: chan_count = 3'h1;
                `SLSM_VAR_DUAL:   chan_count = 3'h2;
                `SLSM_VAR_QUAD:   chan_count = 3'h4;
                default:          chan_count = 3'h0;
            endcase
        end
    endfunction

    // lanes used by one channel in a format
    function [2:0] lanes_per_ch;
        input [`SLSM_FMT_W-1:0] f;
        begin
            case (f)
                `SLSM_FMT_13: lanes_per_ch = 3'h4;
                `SLSM_FMT_14: lanes_per_ch = 3'h2;
                `SLSM_FMT_15: lanes_per_ch = 3'h4;
                default:      lanes_per_ch = 3'h0;
            endcase
        end
    endfunction

    // one 9-bit sample out of the frame
    function [`SLSM_SMP_W-1:0] pick;
        input [`SLSM_FRAME_W-1:0] fr;
        input integer             ch;
        input integer             idx;
        begin
            pick = fr[(ch*`SLSM_SMP_PER_CH + idx)*`SLSM_SMP_W +: `SLSM_SMP_W];
        end
    endfunction

    // lanes switched on, keyed by channels and lanes per channel
    function [`SLSM_LANES-1:0] lane_mask;
        input [`SLSM_FMT_W-1:0] f;
        input [`SLSM_VAR_W-1:0] v;
        begin
            case ({chan_count(v), lanes_per_ch(f)})
                6'h0a:   lane_mask = 8'h03;
                6'h0c:   lane_mask = 8'h0f;
                6'h12:   lane_mask = 8'h0f;
                6'h14:   lane_mask = 8'hff;
                6'h22:   lane_mask = 8'hff;
                default: lane_mask = 8'h00;
            endcase
        end
    endfunction

    // format 13 lane: four 10-bit containers, stride of four samples
    function [`SLSM_LANE_W-1:0] lane13;
        input integer             lane;
        input [`SLSM_FRAME_W-1:0] fr;
        integer j;
        integer ch;
        integer k;
        reg [`SLSM_LANE_W-1:0]    w;
        begin
            w  = {`SLSM_LANE_W{1'b0}};
            ch = lane / 4;
            k  = lane % 4;
            for (j = 0; j < 4; j = j + 1) begin
                w[`SLSM_LANE_W-1-j*`SLSM_CONT10_W -: `SLSM_CONT10_W] =
                    {pick(fr, ch, k + 4*j), `SLSM_PAD10};
            end
            lane13 = w;
        end
    endfunction

    // format 14 lane: two 12-bit containers, even or odd samples
    function [`SLSM_LANE_W-1:0] lane14;
        input integer             lane;
        input [`SLSM_FRAME_W-1:0] fr;
        integer j;
        integer ch;
        integer p;
        reg [`SLSM_LANE_W-1:0]    w;
        begin
            w  = {`SLSM_LANE_W{1'b0}};
            ch = lane / 2;
            p  = lane % 2;
            for (j = 0; j < 2; j = j + 1) begin
                w[`SLSM_LANE_W-1-j*`SLSM_CONT12_W -: `SLSM_CONT12_W] =
                    {pick(fr, ch, p + 2*j), `SLSM_PAD12};
            end
            lane14 = w;
        end
    endfunction

    // format 15 lane: two 12-bit containers, stride of four samples
    function [`SLSM_LANE_W-1:0] lane15;
        input integer             lane;
        input [`SLSM_FRAME_W-1:0] fr;
        integer j;
        integer ch;
        integer k;
        reg [`SLSM_LANE_W-1:0]    w;
        begin
            w  = {`SLSM_LANE_W{1'b0}};
            ch = lane / 4;
            k  = lane % 4;
            for (j = 0; j < 2; j = j + 1) begin
                w[`SLSM_LANE_W-1-j*`SLSM_CONT12_W -: `SLSM_CONT12_W] =
                    {pick(fr, ch, k + 4*j), `SLSM_PAD12};
            end
            lane15 = w;
        end
    endfunction

    // lane word, first octet in the top bits
    function [`SLSM_LANE_W-1:0] map_lane;
        input [`SLSM_FMT_W-1:0]   f;
        input integer             lane;
        input [`SLSM_FRAME_W-1:0] fr;
        begin
            case (f)
                `SLSM_FMT_13: map_lane = lane13(lane, fr);
                `SLSM_FMT_14: map_lane = lane14(lane, fr);
                `SLSM_FMT_15: map_lane = lane15(lane, fr);
                default:      map_lane = {`SLSM_LANE_W{1'b0}};
            endcase
        end
    endfunction

    // legal combinations of format and variant
    always @* begin
        case (link_format_select)
            `SLSM_FMT_13: cfg_ok = (channel_variant == `SLSM_VAR_SINGLE) ||
                                   (channel_variant == `SLSM_VAR_DUAL);
            `SLSM_FMT_14: cfg_ok = (chan_count(channel_variant) != 3'h0);
            `SLSM_FMT_15: cfg_ok = (channel_variant == `SLSM_VAR_SINGLE) ||
                                   (channel_variant == `SLSM_VAR_DUAL);
            default:      cfg_ok = 1'b0;
        endcase
    end

    assign lane_on     = lane_mask(link_format_select, channel_variant);
    assign next_enable = cfg_ok ? lane_on : {`SLSM_LANES{1'b0}};

    genvar g;
    generate
        for (g = 0; g < `SLSM_LANES; g = g + 1) begin : g_lane
            // unused lanes stay off and carry zeros
            assign mapped[g*`SLSM_LANE_W +: `SLSM_LANE_W] = next_enable[g] ?
                map_lane(link_format_select, g, f_data) : {`SLSM_LANE_W{1'b0}};
        end
    endgenerate

    // lane word set captured by the output stage
    always @* begin
        next_data = {(`SLSM_LANES*`SLSM_LANE_W){1'b0}};
        if (cfg_ok) begin
            next_data = mapped;
        end
    end

    // output stage accepts a frame when empty or being drained
    assign f_ready = !lane_valid || lane_ready;

    wire take = f_valid && f_ready;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            lane_valid    <= 1'b0;
            lane_data     <= {(`SLSM_LANES*`SLSM_LANE_W){1'b0}};
            lane_enable   <= {`SLSM_LANES{1'b0}};
            config_error  <= 1'b0;
            frame_dropped <= 1'b0;
        end else begin
            config_error  <= !cfg_ok;
            frame_dropped <= take && !cfg_ok;
            if (take) begin
                lane_valid  <= cfg_ok;
                lane_enable <= next_enable;
                lane_data   <= next_data;
            end else if (lane_ready) begin
                lane_valid <= 1'b0;
            end
        end
    end
endmodule // slsm_mapper

/* slsm_mapper_asserts.sv */
`timescale 1ns/10ps
module slsm_chk (
    // clock and reset
    input wire logic         clock,
    input wire logic         rst,
    // configuration
    input wire logic [3:0]   link_format_select,
    input wire logic [1:0]   channel_variant,
    // streams and status
    input wire logic         smp_valid,
    input wire logic         smp_ready,
    input wire logic         lane_valid,
    input wire logic         lane_ready,
    input wire logic [319:0] lane_data,
    input wire logic [7:0]   lane_enable,
    input wire logic         config_error,
    input wire logic         frame_dropped
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire [5:0] cf = {link_format_select, channel_variant};
    wire       lv = lane_valid;

    property p_en13; lv && cf[5:1] == 5'h1a |-> lane_enable == (cf[0] ? 8'hff : 8'h0f); endproperty
    a_en13: assert property (p_en13) else $error("bad enables, 10-bit mode");
    property p_en14s; lv && cf == 6'h38 |-> lane_enable == 8'h03; endproperty
    a_en14s: assert property (p_en14s) else $error("bad enables, single");
    property p_en14d; lv && cf == 6'h39 |-> lane_enable == 8'h0f; endproperty
    a_en14d: assert property (p_en14d) else $error("bad enables, dual");
    property p_en14q; lv && cf == 6'h3a |-> lane_enable == 8'hff; endproperty
    a_en14q: assert property (p_en14q) else $error("bad enables, quad");
    property p_en15; lv && cf[5:1] == 5'h1e |-> lane_enable == (cf[0] ? 8'hff : 8'h0f); endproperty
    a_en15: assert property (p_en15) else $error("bad enables, 12-bit 4 lane");
    property p_cerr; cf == 6'h36 |=> config_error; endproperty
    a_cerr: assert property (p_cerr) else $error("quad not refused");
    property p_quiet; config_error |-> !lv; endproperty
    a_quiet: assert property (p_quiet) else $error("output under bad config");
    property p_pad13; lv && cf[5:1] == 5'h1a |-> !lane_data[30] && !lane_data[0]; endproperty
    a_pad13: assert property (p_pad13) else $error("pad bit not zero");
    property p_pad14; lv && cf[5:3] == 3'h7 |-> lane_data[30:28] == 0 && lane_data[18:0] == 0;
    endproperty
    a_pad14: assert property (p_pad14) else $error("pad bits not zero");
    property p_drop; frame_dropped |-> config_error && !lv; endproperty
    a_drop: assert property (p_drop) else $error("drop without config error");
    property p_off; lv |-> (lane_enable[7] || lane_data[319:160] == 0) &&
        (lane_enable[2] || lane_data[159:80] == 0); endproperty
    a_off: assert property (p_off) else $error("unused lanes not zero");
    c_take: cover property (lv && lane_ready);
    c_quad: cover property (lv && cf == 6'h3a);
    c_drop: cover property (frame_dropped);
    c_full: cover property (smp_valid && !smp_ready);
endmodule // slsm_chk

bind slsm_mapper slsm_chk chk_u (.clock(clock), .rst(rst),
    .link_format_select(link_format_select), .channel_variant(channel_variant),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .lane_valid(lane_valid),
    .lane_ready(lane_ready), .lane_data(lane_data), .lane_enable(lane_enable),
    .config_error(config_error), .frame_dropped(frame_dropped));

/* slsm_rx_model.sv */
`timescale 1ns/10ps
module slsm_rx_model (
    input wire logic         clock,
    input wire logic [1:0]   mode,
    input wire logic         lane_valid,
    input wire logic [319:0] lane_data,
    input wire logic [7:0]   lane_enable,
    output logic             lane_ready = 0
);
    logic [327:0] got[$];
    // 0 eager, 1 every other cycle, 2 stalled
    always @(negedge clock) lane_ready <= mode == 0 || (mode == 1 && !lane_ready);
    // raw lane words kept; the bench checks the padding bits as zero
    always @(posedge clock) if (lane_valid && lane_ready) got.push_back({lane_enable, lane_data});
endmodule // slsm_rx_model

/* slsm_mapper_tb.sv */
`timescale 1ns/10ps
module slsm_mapper_tb;
    logic         clock = 0, rst = 1, smp_valid = 0;
    logic [3:0]   link_format_select = 4'hd;
    logic [1:0]   channel_variant = 0, mode = 0;
    logic [575:0] smp_frame = 0;
    wire          smp_ready, lane_valid, lane_ready, config_error, frame_dropped;
    wire [319:0]  lane_data;
    wire [7:0]    lane_enable;
    int           failures = 0, check_count = 0, cyc = 0, n;
    // {format, variant, expected lane enables}
    logic [13:0]  rows[7] = '{14'h340f, 14'h35ff, 14'h3803, 14'h390f, 14'h3aff, 14'h3c0f, 14'h3dff};
    // illegal {format, variant}: 13 quad, 14 bad variant, 15 quad, unknown format
    logic [5:0]   bad[4] = '{6'h36, 6'h3b, 6'h3e, 6'h00};

    slsm_mapper dut_u (.clock(clock), .rst(rst), .link_format_select(link_format_select),
        .channel_variant(channel_variant), .smp_valid(smp_valid), .smp_ready(smp_ready),
        .smp_frame(smp_frame), .lane_valid(lane_valid), .lane_ready(lane_ready),
        .lane_data(lane_data), .lane_enable(lane_enable), .config_error(config_error),
        .frame_dropped(frame_dropped));
    slsm_rx_model rx_u (.clock(clock), .mode(mode), .lane_valid(lane_valid),
        .lane_data(lane_data), .lane_enable(lane_enable), .lane_ready(lane_ready));
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            results;
        end
    end

    function automatic [8:0] sm(input [8:0] s, input int c, input int i);
        return s + 9'((c * 16 + i) * 7);
    endfunction
    function automatic [575:0] mk(input [8:0] s);
        for (int k = 0; k < 64; k++) mk[k*9 +: 9] = sm(s, k / 16, k % 16);
    endfunction
    function automatic [39:0] ex(input [3:0] f, input [8:0] s, input int l);
        int c4 = l / 4, k = l % 4;
        if (f == 4'hd) return {sm(s, c4, k), 1'b0, sm(s, c4, k + 4), 1'b0,
            sm(s, c4, k + 8), 1'b0, sm(s, c4, k + 12), 1'b0};
        if (f == 4'he) return {sm(s, l / 2, l % 2), 3'h0, sm(s, l / 2, l % 2 + 2), 3'h0, 16'h0};
        return {sm(s, c4, k), 3'h0, sm(s, c4, k + 4), 3'h0, 16'h0};
    endfunction
    task chk(input string nm, input [327:0] e, input [327:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task send(input [8:0] s);
        smp_frame = mk(s);
        smp_valid = 1;
        while (smp_ready !== 1) @(negedge clock);
        @(negedge clock);
    endtask
    task take(input [3:0] f, input [8:0] s, input [7:0] en);
        logic [327:0] v;
        for (n = 0; n < 50 && rx_u.got.size() == 0; n++) @(negedge clock);
        v = rx_u.got.size() ? rx_u.got.pop_front() : 'x;
        chk("enable", en, v[327:320]);
        for (int l = 0; l < 8; l++) chk("lane", en[l] ? ex(f, s, l) : 40'h0, v[l*40 +: 40]);
    endtask
    task results;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge clock);
        rst = 0;
        chk("ready", 1, smp_ready);
        chk("valid", 0, lane_valid);
        chk("enable0", 0, lane_enable);
        chk("cerr0", 0, config_error);
        foreach (rows[r]) begin
            {link_format_select, channel_variant} = rows[r][13:8];
            mode = 2'(r % 2);
            send(9'(10 + r));
            send(9'(496 + r));
            smp_valid = 0;
            take(rows[r][13:10], 9'(10 + r), rows[r][7:0]);
            take(rows[r][13:10], 9'(496 + r), rows[r][7:0]);
        end
        foreach (bad[b]) begin
            {link_format_select, channel_variant} = bad[b];
            send(9'h3);
            smp_valid = 0;
            for (n = 0; n < 10 && frame_dropped !== 1; n++) @(negedge clock);
            chk("drop", 1, frame_dropped);
            chk("cerr", 1, config_error);
            chk("none", 0, rx_u.got.size());
        end
        mode = 2;
        {link_format_select, channel_variant} = 6'h3a;
        repeat (2) @(negedge clock);
        for (n = 0; n < 8 && smp_ready; n++) begin
            smp_frame = mk(9'(n));
            smp_valid = 1;
            @(negedge clock);
        end
        smp_valid = 0;
        chk("depth", 5, n);
        mode = 0;
        for (int k = 0; k < 5; k++) take(4'he, 9'(k), 8'hff);
        // reset in mid-run with a frame held at the output
        mode = 2;
        send(9'h1);
        send(9'h2);
        smp_valid = 0;
        rst = 1;
        @(negedge clock);
        chk("rst valid", 0, lane_valid);
        chk("rst ready", 1, smp_ready);
        chk("rst enable", 0, lane_enable);
        chk("rst data", 0, lane_data);
        rst = 0;
        mode = 0;
        repeat (4) @(negedge clock);
        chk("flush", 0, rx_u.got.size());
        send(9'h5);
        smp_valid = 0;
        take(4'he, 9'h5, 8'hff);
        results;
    end
endmodule // slsm_mapper_tb
